// file: hw/usfa_pkg.sv
// package: register map, field positions and carrier types for the fifo access block
package usfa_pkg;
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 8;
    // register offsets
    localparam logic [3:0]  OFF_TOKEN_STAT = 4'h0;
    localparam logic [3:0]  OFF_FIFO_CTRL  = 4'h1;
    localparam logic [3:0]  OFF_FIFO_EN    = 4'h2;
    localparam logic [3:0]  OFF_EP0_DATA   = 4'h3;
    localparam logic [3:0]  OFF_EP1_DATA   = 4'h4;
    localparam logic [3:0]  OFF_EP2_DATA   = 4'h5;
    localparam logic [3:0]  OFF_RX_COUNT   = 4'h6;
    localparam logic [3:0]  OFF_ENG_CTRL   = 4'h7;
    localparam logic [3:0]  OFF_DEV_ADDR   = 4'h8;
    // engine_token_status bits
    localparam int          TS_IN          = 3;
    localparam int          TS_OUT         = 2;
    localparam int          TS_ERR         = 1;
    localparam int          TS_ADDR_MODE   = 0;
    // fifo_access_control bits
    localparam int          FC_ZERO_LEN    = 7;
    localparam int          FC_READY       = 6;
    localparam int          FC_SETUP_CMD   = 5;
    localparam int          FC_FLUSH       = 2;
    localparam int          FC_TX          = 1;
    localparam int          FC_REQ         = 0;
    localparam logic [7:0]  FC_WMASK       = 8'h27;
    // endpoint_fifo_enable bits
    localparam int          FE_O2          = 6;
    localparam int          FE_O1          = 5;
    localparam int          FE_I2          = 2;
    localparam int          FE_I1          = 1;
    localparam int          FE_TOG         = 0;
    localparam logic [7:0]  FE_WMASK       = 8'h67;
    localparam logic [7:0]  FE_RESET       = 8'h00;
    localparam logic [7:0]  ADDR_RESET     = 8'h00;
    localparam logic [7:0]  ZERO8          = 8'h00;
    localparam logic [1:0]  EPS_RESET      = 2'h0;
    localparam int          EP_NUM         = 3;
    localparam int          FIFO_DEPTH     = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } usfa_bus_t;

    // engine-side events from the serial interface engine
    typedef struct packed {
        logic       in_token;
        logic       out_data;
        logic       out_zero;
        logic       setup_tok;
        logic       in_ack;
        logic       rx_byte;
        logic [1:0] rx_ep;
        logic [7:0] rx_data;
        logic       tx_pull;
        logic [1:0] tx_ep;
    } usfa_eng_t;

    typedef enum logic [2:0] {
        ACC_IDLE  = 3'b001,
        ACC_READ  = 3'b010,
        ACC_WRITE = 3'b100
    } usfa_acc_t;
endpackage : usfa_pkg

// file: hw/usfa_ep_fifo.sv
// single endpoint byte fifo with flush
`timescale 1ns/100ps
`default_nettype none
module usfa_ep_fifo #(
    parameter int DEPTH = 8,
    parameter int W     = 8
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         flush,
    input  wire logic         push,
    input  wire logic [W-1:0] din,
    input  wire logic         pop,
    output logic      [W-1:0] dout,
    output logic              empty,
    output logic              full
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW:0]   wp_r;
    logic [AW:0]   rp_r;
    logic [W-1:0]  dout_r;

    assign empty = (wp_r == rp_r);
    assign full  = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    assign dout  = dout_r;

    always_ff @(posedge mclk) begin
        if (push && !full) begin
            mem[wp_r[AW-1:0]] <= din;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r   <= '0;
            rp_r   <= '0;
            dout_r <= '0;
        end else if (flush) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop && !empty) begin
                dout_r <= mem[rp_r[AW-1:0]];
                rp_r   <= rp_r + 1'b1;
            end
        end
    end
endmodule : usfa_ep_fifo
`default_nettype wire

// file: hw/usfa_por_reg.sv
// register held only by power-on reset
`timescale 1ns/100ps
`default_nettype none
module usfa_por_reg #(
    parameter int         W     = 8,
    parameter logic [7:0] RST   = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
) (
    input  wire logic         mclk,
    input  wire logic         por_rst,
    input  wire logic         we,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] q
);
    logic [W-1:0] q_r;
    assign q = q_r;
    // other resets deliberately not wired here
    always_ff @(posedge mclk or posedge por_rst) begin
        if (por_rst) begin
            q_r <= RST[W-1:0];
        end else if (we) begin
            q_r <= wdata & WMASK[W-1:0];
        end
    end
endmodule : usfa_por_reg
`default_nettype wire

// file: hw/usfa_core.sv
// fifo access control, token status and address update logic
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module usfa_core #(
    parameter int DEPTH = usfa_pkg::FIFO_DEPTH
) (
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic                 por_rst,
    input  wire usfa_pkg::usfa_bus_t  bus,
    output logic [7:0]                rdata,
    input  wire usfa_pkg::usfa_eng_t  eng,
    input  wire logic [1:0]           endpoint_select,
    output logic [7:0]                tx_data,
    output logic                      tx_valid,
    output logic                      force_tx_err,
    output logic                      data_pid_toggle,
    output logic [6:0]                device_address,
    output logic                      remote_wake_en,
    output logic [2:0]                out_fifo_enable,
    output logic [2:0]                in_fifo_enable
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic                 in_tok_r;
    logic                 out_flag_r;
    logic                 err_flag_r;
    logic                 address_update_mode_r;
    logic                 zero_length_packet_flag_r;
    logic                 setup_command_flag_r;
    logic                 flush_r;
    logic                 tx_dir_r;
    logic                 req_r;
    logic [7:0]           dev_addr_reg_r;
    logic [6:0]           dev_addr_r;
    logic                 addr_pend_r;
    logic [7:0]           rx_cnt_r;
    logic [7:0]           rdata_r;
    logic [7:0]           tx_data_r;
    logic                 tx_valid_r;
    logic [2:0]           flushed_r;
    logic                 fterr_r;
    logic [7:0]           fen_q;
    usfa_pkg::usfa_acc_t  acc_r;

    logic [1:0]           sel_ep;
    logic [2:0]           f_empty;
    logic [2:0]           f_full;
    logic [2:0]           f_push;
    logic [2:0]           f_pop;
    logic [2:0]           f_flush;
    logic [7:0]           f_dout [3];
    logic [7:0]           f_din  [3];
    logic                 wr_tok;
    logic                 wr_ctrl;
    logic                 wr_dev;
    logic                 data_wr;
    logic                 data_rd;
    logic [1:0]           data_ep;
    logic                 ready_w;
    logic                 acc_err;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] ep_decode(input logic [1:0] s);
        ep_decode = (s == 2'h0) ? 2'h0 : (s == 2'h1) ? 2'h1 : 2'h2;
    endfunction : ep_decode

    function automatic logic is_data_port(input logic [3:0] a);
        is_data_port = (a == usfa_pkg::OFF_EP0_DATA) || (a == usfa_pkg::OFF_EP1_DATA)
                    || (a == usfa_pkg::OFF_EP2_DATA);
    endfunction : is_data_port

    assign sel_ep  = ep_decode(endpoint_select);
    assign wr_tok  = bus.wr && (bus.addr == usfa_pkg::OFF_TOKEN_STAT);
    assign wr_ctrl = bus.wr && (bus.addr == usfa_pkg::OFF_FIFO_CTRL);
    assign wr_dev  = bus.wr && (bus.addr == usfa_pkg::OFF_DEV_ADDR);
    assign data_wr = bus.wr && is_data_port(bus.addr);
    assign data_rd = bus.rd && is_data_port(bus.addr);
    assign data_ep = 2'(bus.addr - usfa_pkg::OFF_EP0_DATA);

    // enables: endpoint 0 always on
    assign out_fifo_enable = {fen_q[usfa_pkg::FE_O2], fen_q[usfa_pkg::FE_O1], 1'b1};
    assign in_fifo_enable  = {fen_q[usfa_pkg::FE_I2], fen_q[usfa_pkg::FE_I1], 1'b1};
    assign data_pid_toggle = fen_q[usfa_pkg::FE_TOG];

    // ----------------------------------------------------------------
    // endpoint fifos
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < usfa_pkg::EP_NUM; g++) begin : g_ep
            // firmware writes into in fifo, engine fills from out data
            assign f_push[g]  = (data_wr && data_ep == 2'(g) && in_fifo_enable[g])
                             || (eng.rx_byte && eng.rx_ep == 2'(g) && out_fifo_enable[g]);
            assign f_din[g]   = data_wr ? bus.wdata : eng.rx_data;
            assign f_pop[g]   = (data_rd && data_ep == 2'(g))
                             || (eng.tx_pull && eng.tx_ep == 2'(g) && in_fifo_enable[g]);
            assign f_flush[g] = flush_r && (sel_ep == 2'(g));
            usfa_ep_fifo #(.DEPTH(DEPTH), .W(usfa_pkg::DATA_W)) u_fifo (
                .mclk    (mclk),
                .sys_rst (sys_rst),
                .flush   (f_flush[g]),
                .push    (f_push[g]),
                .din     (f_din[g]),
                .pop     (f_pop[g]),
                .dout    (f_dout[g]),
                .empty   (f_empty[g]),
                .full    (f_full[g])
            );
        end
    endgenerate

    usfa_por_reg #(.W(8), .RST(usfa_pkg::FE_RESET), .WMASK(usfa_pkg::FE_WMASK)) u_fen (
        .mclk    (mclk),
        .por_rst (por_rst),
        .we      (bus.wr && bus.addr == usfa_pkg::OFF_FIFO_EN),
        .wdata   (bus.wdata),
        .q       (fen_q)
    );

    // ----------------------------------------------------------------
    // access handshake
    // ----------------------------------------------------------------
    // direction latched when the request rises: a write drops its flag before the request
    assign ready_w = req_r && (
        (acc_r == usfa_pkg::ACC_WRITE) ? (!f_full[sel_ep] && in_fifo_enable[sel_ep]) :
        (acc_r == usfa_pkg::ACC_READ)  ? (!f_empty[sel_ep] && out_fifo_enable[sel_ep]) :
        1'b0);
    assign acc_err = (data_wr && f_full[data_ep]) || (data_rd && f_empty[data_ep])
                  || ((data_wr || data_rd) && !req_r);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= usfa_pkg::ACC_IDLE;
        end else begin
            case (acc_r)
                usfa_pkg::ACC_IDLE: begin
                    if (req_r) begin
                        acc_r <= tx_dir_r ? usfa_pkg::ACC_WRITE : usfa_pkg::ACC_READ;
                    end
                end
                usfa_pkg::ACC_READ,
                usfa_pkg::ACC_WRITE: begin
                    if (!req_r) begin
                        acc_r <= usfa_pkg::ACC_IDLE;
                    end
                end
                default: acc_r <= usfa_pkg::ACC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // token status flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            in_tok_r <= 1'b0;
        end else begin
            in_tok_r <= eng.in_token;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            out_flag_r <= 1'b0;
        end else if (eng.out_data && !eng.out_zero) begin
            out_flag_r <= 1'b1;
        end else if (eng.setup_tok || (wr_tok && !bus.wdata[usfa_pkg::TS_OUT])) begin
            out_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            err_flag_r <= 1'b0;
        end else if (acc_err) begin
            err_flag_r <= 1'b1;
        end else if (wr_tok) begin
            err_flag_r <= bus.wdata[usfa_pkg::TS_ERR];
        end
    end

    // firmware owns clearing the mode bit after setup
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            address_update_mode_r <= 1'b0;
        end else if (wr_tok) begin
            address_update_mode_r <= bus.wdata[usfa_pkg::TS_ADDR_MODE];
        end
    end

    // ----------------------------------------------------------------
    // address update
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dev_addr_reg_r <= usfa_pkg::ADDR_RESET;
            dev_addr_r     <= '0;
            addr_pend_r    <= 1'b0;
        end else begin
            if (wr_dev) begin
                dev_addr_reg_r <= bus.wdata;
            end
            if (wr_dev && !address_update_mode_r) begin
                dev_addr_r  <= bus.wdata[7:1];
                addr_pend_r <= 1'b0;
            end else if (wr_dev) begin
                addr_pend_r <= 1'b1;
            end else if (addr_pend_r && address_update_mode_r && eng.in_ack) begin
                dev_addr_r  <= dev_addr_reg_r[7:1];
                addr_pend_r <= 1'b0;
            end else if (!address_update_mode_r) begin
                addr_pend_r <= 1'b0;
            end
        end
    end
    assign device_address = dev_addr_r;
    assign remote_wake_en = dev_addr_reg_r[0];

    // ----------------------------------------------------------------
    // fifo control flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_length_packet_flag_r <= 1'b0;
        end else if (eng.out_zero) begin
            zero_length_packet_flag_r <= 1'b1;
        end else if (data_rd && data_ep == sel_ep) begin
            zero_length_packet_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            setup_command_flag_r <= 1'b0;
        end else if (eng.setup_tok) begin
            setup_command_flag_r <= 1'b1;
        end else if (wr_ctrl && !bus.wdata[usfa_pkg::FC_SETUP_CMD]) begin
            setup_command_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flush_r  <= 1'b0;
            tx_dir_r <= 1'b0;
            req_r    <= 1'b0;
        end else if (wr_ctrl) begin
            flush_r  <= bus.wdata[usfa_pkg::FC_FLUSH];
            tx_dir_r <= bus.wdata[usfa_pkg::FC_TX];
            req_r    <= bus.wdata[usfa_pkg::FC_REQ];
        end
    end

    // flushed endpoint stays armed until firmware writes it again in a cycle with no engine rx_byte
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flushed_r <= '0;
            fterr_r   <= 1'b0;
        end else begin
            fterr_r <= 1'b0;
            for (int i = 0; i < usfa_pkg::EP_NUM; i++) begin
                if (f_flush[i]) begin
                    flushed_r[i] <= 1'b1;
                end else if (f_push[i] && !eng.rx_byte) begin
                    flushed_r[i] <= 1'b0;
                end
            end
            if (eng.tx_pull && flushed_r[eng.tx_ep] && f_empty[eng.tx_ep]) begin
                fterr_r <= 1'b1;
            end
        end
    end
    assign force_tx_err = fterr_r;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_cnt_r <= usfa_pkg::ZERO8;
        end else if (eng.setup_tok || eng.out_zero) begin
            rx_cnt_r <= usfa_pkg::ZERO8;
        end else if (eng.rx_byte) begin
            rx_cnt_r <= rx_cnt_r + 8'h01;
        end else if (bus.wr && bus.addr == usfa_pkg::OFF_RX_COUNT) begin
            rx_cnt_r <= bus.wdata;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_data_r  <= '0;
            tx_valid_r <= 1'b0;
        end else begin
            tx_valid_r <= eng.tx_pull && !f_empty[eng.tx_ep] && in_fifo_enable[eng.tx_ep];
            if (eng.tx_pull) begin
                tx_data_r <= f_dout[eng.tx_ep];
            end
        end
    end
    assign tx_data  = tx_data_r;
    assign tx_valid = tx_valid_r;

    // ----------------------------------------------------------------
    // read port: data one cycle after strobe
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (bus.rd) begin
            case (bus.addr)
                usfa_pkg::OFF_TOKEN_STAT: rdata_r <= {4'h0, in_tok_r, out_flag_r, err_flag_r,
                                                      address_update_mode_r};
                usfa_pkg::OFF_FIFO_CTRL:  rdata_r <= {zero_length_packet_flag_r, ready_w,
                                                      setup_command_flag_r, 2'h0,
                                                      flush_r, tx_dir_r, req_r};
                usfa_pkg::OFF_FIFO_EN:    rdata_r <= fen_q;
                usfa_pkg::OFF_EP0_DATA,
                usfa_pkg::OFF_EP1_DATA,
                usfa_pkg::OFF_EP2_DATA:   rdata_r <= f_dout[data_ep];
                usfa_pkg::OFF_RX_COUNT:   rdata_r <= rx_cnt_r;
                usfa_pkg::OFF_ENG_CTRL:   rdata_r <= {6'h00, endpoint_select};
                usfa_pkg::OFF_DEV_ADDR:   rdata_r <= dev_addr_reg_r;
                default:                  rdata_r <= usfa_pkg::ZERO8;
            endcase
        end
    end
    assign rdata = rdata_r;
endmodule : usfa_core
`default_nettype wire

// file: tb/usfa_core_props.sv
// checker: port-level properties of the fifo access core
`timescale 1ns/100ps
`default_nettype none
module usfa_core_chk (
    input wire logic                mclk,
    input wire logic                sys_rst,
    input wire logic                por_rst,
    input wire usfa_pkg::usfa_bus_t bus,
    input wire logic [7:0]          rdata,
    input wire usfa_pkg::usfa_eng_t eng,
    input wire logic                tx_valid,
    input wire logic                force_tx_err,
    input wire logic                data_pid_toggle,
    input wire logic [6:0]          device_address,
    input wire logic                remote_wake_en,
    input wire logic [2:0]          out_fifo_enable,
    input wire logic [2:0]          in_fifo_enable
);
    logic      address_update_mode_r;
    logic      req_r;
    wire logic wa = bus.wr && bus.addr == usfa_pkg::OFF_DEV_ADDR;
    wire logic we = bus.wr && bus.addr == usfa_pkg::OFF_FIFO_EN;
    wire logic rc = bus.rd && bus.addr == usfa_pkg::OFF_FIFO_CTRL;
    // firmware-side mirror of mode and request bits
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            address_update_mode_r <= 1'b0;
            req_r  <= 1'b0;
        end else if (bus.wr) begin
            if (bus.addr == usfa_pkg::OFF_TOKEN_STAT) address_update_mode_r <= bus.wdata[0];
            if (bus.addr == usfa_pkg::OFF_FIFO_CTRL) req_r <= bus.wdata[0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst || por_rst);
    a_addr_direct: assert property (wa && !address_update_mode_r |=>
        device_address == $past(bus.wdata[7:1])) else $error("address not adopted");
    a_wake_bit: assert property (wa |=> remote_wake_en == $past(bus.wdata[0]))
        else $error("wake enable wrong");
    a_pid_toggle: assert property (we |=> data_pid_toggle == $past(bus.wdata[0]))
        else $error("toggle wrong");
    a_out_enable: assert property (we |=> out_fifo_enable == {$past(bus.wdata[6:5]), 1'b1})
        else $error("out enables wrong");
    a_in_enable: assert property (we |=> in_fifo_enable == {$past(bus.wdata[2:1]), 1'b1})
        else $error("in enables wrong");
    a_por_only: assert property (disable iff (por_rst) sys_rst |->
        $stable({data_pid_toggle, out_fifo_enable, in_fifo_enable})) else $error("enables lost");
    a_rsv_zero: assert property (bus.rd && bus.addr inside {1, 2} |=> rdata[4:3] == 2'h0)
        else $error("reserved bits set");
    a_ready_req: assert property (rc && !req_r |=> !rdata[6])
        else $error("ready without request");
    a_flush_err: assert property (force_tx_err |-> $past(eng.tx_pull))
        else $error("stray transmit error");
    a_tx_cause: assert property (tx_valid |-> $past(eng.tx_pull) && !force_tx_err)
        else $error("stray transmit byte");
    c_pull: cover property (tx_valid);
    c_err: cover property (force_tx_err);
    c_pend: cover property (wa && address_update_mode_r);
endmodule : usfa_core_chk
bind usfa_core usfa_core_chk i_usfa_core_chk (.mclk, .sys_rst, .por_rst, .bus, .rdata, .eng,
    .tx_valid, .force_tx_err, .data_pid_toggle, .device_address, .remote_wake_en,
    .out_fifo_enable, .in_fifo_enable);
`default_nettype wire

// file: tb/usfa_host_model.sv
// engine-side event source standing in for the usb host
`timescale 1ns/100ps
`default_nettype none
module usfa_host_model (
    input  wire logic               mclk,
    output var usfa_pkg::usfa_eng_t eng
);
    logic in_lvl = 1'b0;
    initial eng = '0;
    // k = out_data, out_zero, setup, in_ack, rx_byte, tx_pull
    task automatic send(input logic [5:0] k, input logic [1:0] ep, input logic [7:0] d);
        usfa_pkg::usfa_eng_t e;
        e = '0;
        {e.out_data, e.out_zero, e.setup_tok, e.in_ack, e.rx_byte, e.tx_pull} = k;
        e.in_token = in_lvl;
        e.rx_ep = ep;
        e.tx_ep = ep;
        e.rx_data = d;
        @(posedge mclk);
        eng <= e;
        e = '0;
        e.in_token = in_lvl;
        // idle byte inverted so stale data never looks valid
        e.rx_data = ~d;
        @(posedge mclk);
        eng <= e;
    endtask : send
    task automatic set_in(input logic v);
        @(posedge mclk);
        in_lvl = v;
        eng.in_token <= v;
    endtask : set_in
endmodule : usfa_host_model
`default_nettype wire

// file: tb/usfa_core_tb.sv
// testbench: register, token and fifo scenarios for the access core
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module usfa_core_tb;
    logic                mclk;
    logic                sys_rst;
    logic                por_rst;
    logic [1:0]          endpoint_select;
    usfa_pkg::usfa_bus_t bus;
    usfa_pkg::usfa_eng_t eng;
    logic [7:0]          rdata, tx_data;
    logic                tx_valid, force_tx_err, data_pid_toggle, remote_wake_en;
    logic [6:0]          device_address;
    logic [2:0]          out_fifo_enable, in_fifo_enable;
    int                  error_cnt = 0;
    int                  comparisons = 0;
    int                  cyc = 0;
    usfa_core #(.DEPTH(usfa_pkg::FIFO_DEPTH)) i_usfa_core (.mclk, .sys_rst, .por_rst, .bus,
        .rdata, .eng, .endpoint_select, .tx_data, .tx_valid, .force_tx_err, .data_pid_toggle,
        .device_address, .remote_wake_en, .out_fifo_enable, .in_fifo_enable);
    usfa_host_model i_usfa_host_model (.mclk, .eng);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // scenarios take about 113 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '{addr: a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr
    task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        #1 `CHK("rdata", e, rdata & m)
    endtask : rc
    task automatic h(input logic [5:0] k, input logic [1:0] ep, input logic [7:0] d);
        i_usfa_host_model.send(k, ep, d);
    endtask : h
    task automatic t_reset;
        rc(4'h2, 8'hFF, 8'h00);
        `CHK("in_en", 3'h1, in_fifo_enable)
    endtask : t_reset
    task automatic t_enables;
        wr(4'h2, 8'hFF);
        rc(4'h2, 8'hFF, 8'h67);
        `CHK("out_en", 3'h7, out_fifo_enable)
        `CHK("tog", 1'b1, data_pid_toggle)
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rc(4'h2, 8'hFF, 8'h67);
    endtask : t_enables
    task automatic t_addr;
        wr(4'h8, 8'hA5);
        @(posedge mclk);
        #1 `CHK("addr", 7'h52, device_address)
        `CHK("wake", 1'b1, remote_wake_en)
        wr(4'h0, 8'h01);
        wr(4'h8, 8'h14);
        @(posedge mclk);
        #1 `CHK("addr", 7'h52, device_address)
        h(6'h04, 2'h0, 8'h00);
        repeat (2) @(posedge mclk);
        #1 `CHK("addr", 7'h0A, device_address)
        wr(4'h0, 8'h00);
    endtask : t_addr
    task automatic t_tokens;
        i_usfa_host_model.set_in(1'b1);
        rc(4'h0, 8'h08, 8'h08);
        i_usfa_host_model.set_in(1'b0);
        rc(4'h0, 8'h08, 8'h00);
        h(6'h10, 2'h0, 8'h00);
        rc(4'h0, 8'h04, 8'h00);
        rc(4'h1, 8'h80, 8'h80);
        rc(4'h3, 8'h00, 8'h00);
        rc(4'h1, 8'h80, 8'h00);
        wr(4'h0, 8'h00);
        h(6'h20, 2'h0, 8'h00);
        rc(4'h0, 8'h04, 8'h04);
        h(6'h08, 2'h0, 8'h00);
        rc(4'h0, 8'h04, 8'h00);
        rc(4'h1, 8'h20, 8'h20);
        wr(4'h1, 8'h00);
        rc(4'h1, 8'h20, 8'h00);
    endtask : t_tokens
    task automatic t_count;
        h(6'h02, 2'h1, 8'h3C);
        h(6'h02, 2'h1, 8'hC3);
        rc(4'h6, 8'hFF, 8'h02);
        wr(4'h6, 8'h07);
        rc(4'h6, 8'hFF, 8'h07);
    endtask : t_count
    task automatic t_err;
        rc(4'h4, 8'h00, 8'h00);
        rc(4'h0, 8'h02, 8'h02);
        wr(4'h0, 8'h00);
        rc(4'h0, 8'h02, 8'h00);
        rc(4'hF, 8'hFF, 8'h00);
    endtask : t_err
    task automatic t_ready;
        @(posedge mclk);
        endpoint_select <= 2'h1;
        wr(4'h1, 8'h03);
        wr(4'h4, 8'h5A);
        rc(4'h1, 8'h40, 8'h40);
        wr(4'h1, 8'h01);
        wr(4'h1, 8'h00);
        rc(4'h1, 8'h40, 8'h00);
        h(6'h01, 2'h1, 8'h00);
        #1 `CHK("txv", 1'b1, tx_valid)
        `CHK("txd", 8'h3C, tx_data)
    endtask : t_ready
    task automatic t_flush;
        @(posedge mclk);
        endpoint_select <= 2'h3;
        rc(4'h7, 8'hFF, 8'h03);
        wr(4'h1, 8'h04);
        wr(4'h1, 8'h00);
        h(6'h01, 2'h2, 8'h00);
        #1 `CHK("txerr", 1'b1, force_tx_err)
    endtask : t_flush
    initial begin
        sys_rst = 1'b1;
        por_rst = 1'b1;
        endpoint_select = 2'h0;
        bus = '0;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        t_reset();
        t_enables();
        t_addr();
        t_tokens();
        t_count();
        t_err();
        t_ready();
        t_flush();
        conclude();
    end
endmodule : usfa_core_tb
`default_nettype wire
